// >>> core/fss_defs.svh
`ifndef FSS_DEFS_SVH
`define FSS_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the 32-bit register port)
// ----------------------------------------------------------------------
`define FSS_OFF_STATUS 8'h00
`define FSS_OFF_TAG 8'h04
`define FSS_OFF_CTRL 8'h08
`define FSS_OFF_CMD 8'h0C
`define FSS_OFF_OPND0 8'h10
`define FSS_OFF_OPND1 8'h14
`define FSS_OFF_OPND2 8'h18
`define FSS_OFF_RES0 8'h1C
`define FSS_OFF_RES1 8'h20
`define FSS_OFF_RES2 8'h24

// ----------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------
`define FSS_SW_BUSY 15
`define FSS_SW_COND3 14
`define FSS_SW_TOP_HI 13
`define FSS_SW_TOP_LO 11
`define FSS_SW_COND2 10
`define FSS_SW_COND1 9
`define FSS_SW_COND0 8
`define FSS_SW_SUMMARY 7
`define FSS_SW_STKFLT 6
`define FSS_SW_EXC_HI 5
`define FSS_SW_INVALID 0

// ----------------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------------
`define FSS_CMD_OP_HI 3
`define FSS_CMD_IDX_HI 6
`define FSS_CMD_IDX_LO 4
`define FSS_CMD_CC_HI 11
`define FSS_CMD_CC_LO 8
`define FSS_CMD_EXC_HI 17
`define FSS_CMD_EXC_LO 12
`define FSS_CMD_Q_HI 20
`define FSS_CMD_Q_LO 18
`define FSS_CMD_INCMP 21

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FSS_RST_TAG 16'hFFFF
`define FSS_RST_MASK 6'h3F
`define FSS_RST_TOP 3'h0

`endif

// >>> core/fss_pkg.sv
package fss_pkg;

  // Command codes written to the command register.
  typedef enum logic [3:0] {
    OP_NOP,
    OP_PUSH,
    OP_POP,
    OP_STORE_ST,
    OP_FETCH_ST,
    OP_CC_UPDATE,
    OP_PREM,
    OP_FREE_ST
  } fss_op_t;

  // Two-bit register tag codes.
  typedef enum logic [1:0] {
    TAG_VALID,
    TAG_ZERO,
    TAG_SPECIAL,
    TAG_EMPTY
  } fss_tag_t;

endpackage

// >>> core/fss_status_if.sv
`timescale 1ns/1ps
interface fss_status_if;
  logic loadEn;
  logic [15:0] loadWord;
  logic ccWe;
  logic [3:0] ccVal;
  logic [5:0] excSet;
  logic sfSet;
  logic c1Fault;
  logic topWe;
  logic [2:0] topVal;
  logic [5:0] maskBits;
  logic [2:0] top;
  logic [15:0] statusWord;
  logic errorOut;

  modport ctl (
    output loadEn, loadWord, ccWe, ccVal, excSet, sfSet, c1Fault,
    output topWe, topVal, maskBits,
    input top, statusWord, errorOut
  );
  modport stat (
    input loadEn, loadWord, ccWe, ccVal, excSet, sfSet, c1Fault,
    input topWe, topVal, maskBits,
    output top, statusWord, errorOut
  );
endinterface

// >>> core/fss_status_unit.sv
`timescale 1ns/1ps
`include "fss_defs.svh"

module fss_status_unit (
  input wire logic core_clk,
  input wire logic reset,
  fss_status_if.stat sif
);

  logic [2:0] top_reg;
  logic [3:0] cc_reg;
  logic sf_reg;
  logic [5:0] exc_reg;
  logic errSum;
  logic err_reg;

  // ----------------------------------------------------------------------
  // Stack pointer and condition codes
  // ----------------------------------------------------------------------

  // Top pointer follows an environment load, else stack operations.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      top_reg <= `FSS_RST_TOP;
    end else if (sif.loadEn) begin
      top_reg <= sif.loadWord[`FSS_SW_TOP_HI:`FSS_SW_TOP_LO];
    end else if (sif.topWe) begin
      top_reg <= sif.topVal;
    end
  end

  // Condition codes are held as {c3, c2, c1, c0}.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cc_reg <= 4'h0;
    end else if (sif.loadEn) begin
      cc_reg <= {sif.loadWord[`FSS_SW_COND3], sif.loadWord[`FSS_SW_COND2],
                 sif.loadWord[`FSS_SW_COND1], sif.loadWord[`FSS_SW_COND0]};
    end else if (sif.sfSet) begin
      cc_reg[1] <= sif.c1Fault;
    end else if (sif.ccWe) begin
      cc_reg <= sif.ccVal;
    end
  end

  // ----------------------------------------------------------------------
  // Exception flags and stack fault
  // ----------------------------------------------------------------------

  // Flags are sticky; a set in the cycle of a load is kept.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      exc_reg <= 6'h00;
      sf_reg <= 1'b0;
    end else if (sif.loadEn) begin
      exc_reg <= sif.loadWord[`FSS_SW_EXC_HI:0] | sif.excSet;
      sf_reg <= sif.loadWord[`FSS_SW_STKFLT] | sif.sfSet;
    end else begin
      exc_reg <= exc_reg | sif.excSet;
      sf_reg <= sf_reg | sif.sfSet;
    end
  end

  // Error summary is always derived, never stored from a load.
  assign errSum = |(exc_reg & ~sif.maskBits);

  // Error output follows the summary one cycle later.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= errSum;
    end
  end

  // Status word assembly; bit 15 mirrors the summary.
  assign sif.statusWord = {errSum, cc_reg[3], top_reg, cc_reg[2], cc_reg[1],
                           cc_reg[0], errSum, sf_reg, exc_reg};
  assign sif.top = top_reg;
  assign sif.errorOut = err_reg;

endmodule

// >>> core/fss_stack_status_regs.sv
`timescale 1ns/1ps
`include "fss_defs.svh"


module fss_stack_status_regs #(
  parameter int NUM_REGS = 8,
  parameter int ENTRY_W = 80
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  output logic errorOut
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------

  // The tag word packs two bits per entry into sixteen bits and the
  // pointer field is three bits, so other sizes cannot be served.
  // The pointer and tag word layout serve exactly eight 80-bit entries.
  if (NUM_REGS != 8 || ENTRY_W != 80) begin : gBadParam
    $error("fss_stack_status_regs serves only 8 entries of 80 bits");
  end

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------

  localparam int IDX_W = $clog2(NUM_REGS);

  // Decode results travel to the status unit through this interface.
  fss_status_if sif ();

  logic [ENTRY_W-1:0] stackMem [0:NUM_REGS-1];
  logic [15:0] tag_reg;
  logic [15:0] tag_next;
  logic [5:0] mask_reg;
  logic [ENTRY_W-1:0] opnd_reg;
  logic [ENTRY_W-1:0] res_reg;
  logic [31:0] rdData_reg;

  logic cmdStb;
  fss_pkg::fss_op_t cmdOp;
  logic [IDX_W-1:0] cmdIdx;
  logic [IDX_W-1:0] curTop;
  logic [IDX_W-1:0] pushSlot;
  logic [IDX_W-1:0] relSlot;
  logic pushFault;
  logic popFault;
  logic relFault;
  logic memWe;
  logic [IDX_W-1:0] memAddr;
  logic tagSetValid;
  logic tagSetEmpty;
  logic [IDX_W-1:0] tagSlot;
  logic [3:0] cmdCc;
  logic [2:0] cmdQuot;

  // ----------------------------------------------------------------------
  // Status unit
  // ----------------------------------------------------------------------

  fss_status_unit uStatus (
    .core_clk(core_clk),
    .reset(reset),
    .sif(sif.stat)
  );

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------

  // Command word layout, low bit first:
  //   [3:0]   operation code, one of the package's command codes.
  //   [6:4]   register index, counted from the current top.
  //   [11:8]  condition code value for the update command.
  //   [17:12] exception flags that the operation raises.
  //   [20:18] three low quotient bits of a partial remainder.
  //   [21]    set when the remainder reduction is incomplete.
  // Codes above the last command fall to the default branch and
  // change nothing, so a stray write cannot disturb the stack.
  //
  // A write to the command register runs one operation.
  assign cmdStb = regWrStb && (regAddr == `FSS_OFF_CMD);
  assign cmdOp = fss_pkg::fss_op_t'(regWrData[`FSS_CMD_OP_HI:0]);
  assign cmdIdx = regWrData[`FSS_CMD_IDX_HI:`FSS_CMD_IDX_LO];
  assign cmdCc = regWrData[`FSS_CMD_CC_HI:`FSS_CMD_CC_LO];
  assign cmdQuot = regWrData[`FSS_CMD_Q_HI:`FSS_CMD_Q_LO];
  assign curTop = sif.top;

  // The pointer is three bits wide, so push and pop wrap round the
  // eight entries; the tags, not the pointer, tell full from empty.
  // Physical slots: push target below top, operand relative to top.
  assign pushSlot = curTop - 3'h1;
  assign relSlot = curTop + cmdIdx;

  // A push needs an empty slot below the top, a pop or fetch needs a
  // full one. A fault raises the invalid flag and the stack fault
  // flag, and condition flag 1 tells overflow (1) from underflow (0).
  // A faulting operation leaves the pointer, the tags and the entries
  // as they were, so software can inspect the state that caused it.
  // Stack faults come from the tags of the slots involved.
  assign pushFault = tag_reg[2*pushSlot +: 2] != fss_pkg::TAG_EMPTY;
  assign popFault = tag_reg[2*curTop +: 2] == fss_pkg::TAG_EMPTY;
  assign relFault = tag_reg[2*relSlot +: 2] == fss_pkg::TAG_EMPTY;

  // Every output of the decode has a default at the top, so an idle
  // cycle or an unknown code drives no update at all.
  // Combinational decode of each operation's side effects.
  always_comb begin
    memWe = 1'b0;
    memAddr = relSlot;
    tagSetValid = 1'b0;
    tagSetEmpty = 1'b0;
    tagSlot = relSlot;
    sif.ccWe = 1'b0;
    sif.ccVal = cmdCc;
    sif.excSet = 6'h00;
    sif.sfSet = 1'b0;
    sif.c1Fault = 1'b0;
    sif.topWe = 1'b0;
    sif.topVal = curTop;
    if (cmdStb) begin
      unique case (cmdOp)
        fss_pkg::OP_NOP: begin
        end
        fss_pkg::OP_PUSH: begin
          if (pushFault) begin
            sif.excSet[`FSS_SW_INVALID] = 1'b1;
            sif.sfSet = 1'b1;
            sif.c1Fault = 1'b1;
          end else begin
            sif.topWe = 1'b1;
            sif.topVal = pushSlot;
            memWe = 1'b1;
            memAddr = pushSlot;
            tagSetValid = 1'b1;
            tagSlot = pushSlot;
          end
        end
        fss_pkg::OP_POP: begin
          if (popFault) begin
            sif.excSet[`FSS_SW_INVALID] = 1'b1;
            sif.sfSet = 1'b1;
            sif.c1Fault = 1'b0;
          end else begin
            sif.topWe = 1'b1;
            sif.topVal = curTop + 3'h1;
            tagSetEmpty = 1'b1;
            tagSlot = curTop;
          end
        end
        fss_pkg::OP_STORE_ST: begin
          memWe = 1'b1;
          tagSetValid = 1'b1;
        end
        fss_pkg::OP_FETCH_ST: begin
          if (relFault) begin
            sif.excSet[`FSS_SW_INVALID] = 1'b1;
            sif.sfSet = 1'b1;
          end
        end
        fss_pkg::OP_CC_UPDATE: begin
          sif.ccWe = 1'b1;
          sif.excSet = regWrData[`FSS_CMD_EXC_HI:`FSS_CMD_EXC_LO];
        end
        fss_pkg::OP_PREM: begin
          sif.ccWe = 1'b1;
          sif.ccVal = {cmdQuot[0], regWrData[`FSS_CMD_INCMP], cmdQuot[1],
                       cmdQuot[2]};
          sif.excSet = regWrData[`FSS_CMD_EXC_HI:`FSS_CMD_EXC_LO];
        end
        fss_pkg::OP_FREE_ST: begin
          tagSetEmpty = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // A status write behaves as an environment load or state restore:
  // pointer, condition flags, stack fault and exception flags are taken
  // from the word, while bits 15 and 7 are rebuilt from the flags and
  // the masks inside the status unit.
  // Environment load: a status write replaces the word, summary derived.
  assign sif.loadEn = regWrStb && (regAddr == `FSS_OFF_STATUS);
  assign sif.loadWord = regWrData[15:0];
  assign sif.maskBits = mask_reg;

  // ----------------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------------

  // The entries carry no reset; software must push or store before it
  // reads. Only one entry is written per cycle, from the operand stage.
  // Entries hold sign, 15-bit exponent and 64-bit significand.
  always_ff @(posedge core_clk) begin
    if (memWe) begin
      stackMem[memAddr] <= opnd_reg;
    end
  end

  // The result register keeps its value after an underflow, so a
  // faulting pop does not destroy the last good result.
  // Pop and fetch deliver the addressed entry before the pointer moves.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      res_reg <= '0;
    end else if (cmdStb && cmdOp == fss_pkg::OP_POP && !popFault) begin
      res_reg <= stackMem[curTop];
    end else if (cmdStb && cmdOp == fss_pkg::OP_FETCH_ST && !relFault) begin
      res_reg <= stackMem[relSlot];
    end
  end

  // The 80-bit operand is staged before the command that uses it; the
  // upper half of the third word is dropped. The stage keeps its value,
  // so one operand can feed several stores.
  // Operand staging is loaded from the register port in three words.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      opnd_reg <= '0;
    end else if (regWrStb) begin
      if (regAddr == `FSS_OFF_OPND0) begin
        opnd_reg[31:0] <= regWrData;
      end
      if (regAddr == `FSS_OFF_OPND1) begin
        opnd_reg[63:32] <= regWrData;
      end
      if (regAddr == `FSS_OFF_OPND2) begin
        opnd_reg[79:64] <= regWrData[15:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Tag word
  // ----------------------------------------------------------------------

  // Tag codes: 00 valid, 01 zero, 10 special, 11 empty. Entry g owns
  // bits 2g+1 to 2g. A stack operation wins over a bus write to the
  // tag word in the same cycle; the bus cannot issue both at once.
  // Each two-bit tag follows a bus write or the stack operations.
  for (genvar g = 0; g < NUM_REGS; g++) begin : gTag
    always_comb begin
      if (tagSetValid && tagSlot == IDX_W'(g)) begin
        tag_next[2*g +: 2] = fss_pkg::TAG_VALID;
      end else if (tagSetEmpty && tagSlot == IDX_W'(g)) begin
        tag_next[2*g +: 2] = fss_pkg::TAG_EMPTY;
      end else if (regWrStb && regAddr == `FSS_OFF_TAG) begin
        tag_next[2*g +: 2] = regWrData[2*g +: 2];
      end else begin
        tag_next[2*g +: 2] = tag_reg[2*g +: 2];
      end
    end
  end

  // Tag register; all entries start empty.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tag_reg <= `FSS_RST_TAG;
    end else begin
      tag_reg <= tag_next;
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------

  // A set mask bit keeps its exception flag out of the error summary.
  // Masks take effect at once, so unmasking a pending flag raises the
  // summary and, one cycle later, the error output.
  // Exception masks; all masked after reset.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mask_reg <= `FSS_RST_MASK;
    end else if (regWrStb && regAddr == `FSS_OFF_CTRL) begin
      mask_reg <= regWrData[5:0];
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------

  // Register map, byte offsets:
  //   00 status word, read; a write loads it as described above.
  //   04 tag word, read and write.
  //   08 exception masks in bits 5 to 0, read and write.
  //   0C command, write only; reads return zero.
  //   10, 14, 18 operand stage, low word first, read and write.
  //   1C, 20, 24 result of the last pop or fetch, read only.
  // Any other offset reads as zero, and writes to it are ignored.
  // Data are zero outside the read slot so that several slaves could
  // share the read bus through a plain OR.
  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdData_reg <= 32'h0000_0000;
    end else if (regRdStb) begin
      unique case (regAddr)
        `FSS_OFF_STATUS: rdData_reg <= {16'h0000, sif.statusWord};
        `FSS_OFF_TAG: rdData_reg <= {16'h0000, tag_reg};
        `FSS_OFF_CTRL: rdData_reg <= {26'h0000000, mask_reg};
        `FSS_OFF_OPND0: rdData_reg <= opnd_reg[31:0];
        `FSS_OFF_OPND1: rdData_reg <= opnd_reg[63:32];
        `FSS_OFF_OPND2: rdData_reg <= {16'h0000, opnd_reg[79:64]};
        `FSS_OFF_RES0: rdData_reg <= res_reg[31:0];
        `FSS_OFF_RES1: rdData_reg <= res_reg[63:32];
        `FSS_OFF_RES2: rdData_reg <= {16'h0000, res_reg[79:64]};
        default: rdData_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdData_reg <= 32'h0000_0000;
    end
  end

  // Both outputs come straight from flip-flops.
  assign regRdData = rdData_reg;
  assign errorOut = sif.errorOut;

endmodule

// >>> verification/fss_stack_checker.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port checks of the status word and the error output.
// ---------------------------------------------------------------
module fss_stack_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [31:0] regRdData,
  input wire logic errorOut
);
  logic [5:0] maskReg;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // Shadow of the exception masks, used to predict the summary bit.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      maskReg <= 6'h3F;
    end else if (regWrStb && regAddr == 8'h08) begin
      maskReg <= regWrData[5:0];
    end
  end

  sequence sRdStat;
    regRdStb && regAddr == 8'h00;
  endsequence

  sequence sLoad;
    regWrStb && regAddr == 8'h00;
  endsequence

  AST_RD_IDLE: assert property (!regRdStb |=> regRdData == 32'h0)
    else $error("read data not zero outside the read slot");
  AST_BUSY_MIRROR: assert property (sRdStat |=>
    regRdData[15] == regRdData[7] && regRdData[31:16] == 16'h0)
    else $error("busy mirror differs from summary bit");
  AST_ES_UNMASKED: assert property (sRdStat |=>
    regRdData[7] == |(regRdData[5:0] & ~maskReg))
    else $error("summary bit does not match unmasked flags");
  AST_ERR_MATCH: assert property (sRdStat |=> errorOut == regRdData[7])
    else $error("error output differs from summary bit");
  AST_LOAD_SET: assert property (
    sLoad ##0 (|(regWrData[5:0] & ~maskReg)) |=> ##1 errorOut)
    else $error("error output late after status load");
  AST_LOAD_CLR: assert property (
    sLoad ##0 !(|(regWrData[5:0] & ~maskReg)) |=> ##1 !errorOut)
    else $error("error output set after clean status load");
  AST_LOAD_FIELDS: assert property (sLoad ##1 sRdStat |=>
    {regRdData[14:8], regRdData[6:0]} ==
    {$past(regWrData[14:8], 2), $past(regWrData[6:0], 2)})
    else $error("loaded status fields not kept");
  AST_ERR_CAUSE: assert property (
    $changed(errorOut) && !$past(reset) |-> $past(regWrStb, 2))
    else $error("error output moved without a write");
endmodule

bind fss_stack_status_regs fss_stack_checker chk_u (
  .core_clk(core_clk), .reset(reset), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
  .regRdData(regRdData), .errorOut(errorOut));

// >>> verification/fss_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host side of the register port: one-cycle strobes, no waits.
// ---------------------------------------------------------------
module fss_host_model (
  input wire logic core_clk,
  output logic [7:0] regAddr,
  output logic [31:0] regWrData,
  output logic regWrStb,
  output logic regRdStb
);
  // The port is idle at time zero.
  initial begin
    regAddr = 8'hFF;
    regWrData = 32'h0;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
  end

  // One bus cycle; the caller sits just after a rising edge.
  task automatic cyc(input logic w, input logic r, input logic [7:0] a,
                     input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= w;
    regRdStb <= r;
    @(posedge core_clk);
  endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk;
  logic reset;
  logic [7:0] regAddr;
  logic [31:0] regWrData;
  logic regWrStb;
  logic regRdStb;
  logic [31:0] regRdData;
  logic errorOut;
  logic [31:0] expQ[$];
  logic rdPend;
  logic rdStat;
  logic [31:0] expV;
  logic [31:0] lfsr;
  logic [79:0] valA;
  logic [79:0] valB;
  logic [79:0] valC;
  logic [3:0] k;
  int num_errors;
  int n_tests;
  int cycles;

  // ---------------------------------------------------------------
  // Clock, design and host.
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  fss_stack_status_regs dut_u (.core_clk(core_clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .errorOut(errorOut));
  fss_host_model host_u (.core_clk(core_clk), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb));

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic newVal(output logic [79:0] v);
    for (int i = 0; i < 80; i++) begin
      lfsr = lfsrNext(lfsr);
      v[i] = lfsr[0];
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.cyc(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    host_u.cyc(1'b0, 1'b1, a, 32'h0);
  endtask

  task automatic rdSt(input logic [15:0] e);
    rd(8'h00, {16'h0, e});
  endtask

  task automatic setOp(input logic [79:0] v);
    wr(8'h10, v[31:0]);
    wr(8'h14, v[63:32]);
    wr(8'h18, {16'h0, v[79:64]});
  endtask

  task automatic push(input logic [79:0] v);
    setOp(v);
    wr(8'h0C, 32'h1);
  endtask

  task automatic rdRes(input logic [79:0] v);
    rd(8'h1C, v[31:0]);
    rd(8'h20, v[63:32]);
    rd(8'h24, {16'h0, v[79:64]});
  endtask

  // Read data stand in the cycle after the strobe; a cycle cap ends hangs.
  always @(posedge core_clk) begin
    if (rdPend === 1'b1) begin
      expV = expQ.pop_front();
      chk("regRdData", regRdData, expV);
      if (rdStat === 1'b1) begin
        chk("errorOut", {31'h0, errorOut}, {31'h0, expV[7]});
      end
    end
    rdPend = regRdStb;
    rdStat = regRdStb && regAddr == 8'h00;
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      test_done();
    end
  end

  // Main sequence.
  initial begin
    reset = 1'b1;
    rdPend = 1'b0;
    rdStat = 1'b0;
    lfsr = 32'h747F;
    num_errors = 0;
    n_tests = 0;
    cycles = 0;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rdSt(16'h0000);
    rd(8'h04, 32'hFFFF);
    rd(8'h08, 32'h3F);
    rd(8'h40, 32'h0);
    newVal(valA);
    newVal(valB);
    push(valA);
    rdSt(16'h3800);
    rd(8'h04, 32'h3FFF);
    push(valB);
    rd(8'h04, 32'h0FFF);
    wr(8'h0C, 32'h14);
    rdRes(valA);
    wr(8'h0C, 32'h2);
    rdRes(valB);
    rdSt(16'h3800);
    wr(8'h0C, 32'h2);
    rdRes(valA);
    rd(8'h04, 32'hFFFF);
    // An empty pop, then the invalid flag is unmasked.
    wr(8'h0C, 32'h2);
    rdSt(16'h0041);
    wr(8'h08, 32'h3E);
    rdSt(16'h80C1);
    wr(8'h00, 32'h8082);
    rdSt(16'h0002);
    wr(8'h00, 32'h0001);
    rdSt(16'h8081);
    wr(8'h00, 32'h0);
    // Fill and overflow, then store, fetch, free and nop.
    for (int i = 0; i < 9; i++) begin
      newVal(valC);
      push(valC);
    end
    rd(8'h04, 32'h0);
    rdSt(16'h82C1);
    newVal(valC);
    setOp(valC);
    wr(8'h0C, 32'h23);
    wr(8'h0C, 32'h24);
    wr(8'h1C, 32'h0);
    rdRes(valC);
    wr(8'h0C, 32'h7);
    rd(8'h04, 32'h3);
    wr(8'h0C, 32'h0);
    rdSt(16'h82C1);
    wr(8'h00, 32'h0);
    for (int i = 0; i < 16; i++) begin
      k = i[3:0];
      wr(8'h0C, {20'h0, k, 8'h05});
      rdSt({1'b0, k[3], 3'b000, k[2:0], 8'h00});
    end
    wr(8'h0C, 32'h3F005);
    rdSt(16'h80BF);
    wr(8'h00, 32'h0);
    for (int i = 0; i < 16; i++) begin
      k = i[3:0];
      wr(8'h0C, {10'h0, k[3], k[2:0], 18'h6});
      rdSt({1'b0, k[0], 3'b000, k[3], k[1], k[2], 8'h00});
    end
    host_u.cyc(1'b0, 1'b0, 8'hFF, 32'h0);
    host_u.cyc(1'b0, 1'b0, 8'hFF, 32'h0);
    test_done();
  end
endmodule
